// ---- hw/coes_defs.svh ----
// Purpose: constants for the communication supervision block
// Assumes: 100 MHz core clock, object dictionary access by index/subindex
// Notes: offsets are dictionary indexes, not byte addresses
// Summary of operation
// - emergency id defaults 80h plus node id
// - only 11-bit emergency identifiers accepted
// - heartbeat consumer watches exactly one producer
// - consumer word: zero, node, time fields
// - heartbeat loss: emergency, fallback, state change
// - nonzero producer time sends periodic heartbeat
// - producer time zero disables heartbeat
// - identity record: four read-only words
// - revision holds major, minor, patch bytes
// - module list: count then product codes
// - no modules: count reads 14, codes zero
// - bus-off, guarding, sync, pdo timeouts fail
// - behaviour 0 preop, 1 none, 2 stopped
// - behaviour values 3 to 255 refused
// - lifetime is guard time times factor
`ifndef COES_DEFS_SVH
`define COES_DEFS_SVH
`define COES_IDX_GUARD 16'h100C
`define COES_IDX_LIFE 16'h100D
`define COES_IDX_EMCY 16'h1014
`define COES_IDX_CONS 16'h1016
`define COES_IDX_PROD 16'h1017
`define COES_IDX_IDENT 16'h1018
`define COES_IDX_MODS 16'h1027
`define COES_IDX_ERRB 16'h1029
`define COES_EMCY_BASE 11'h080
`define COES_EMCY_HB_CODE 16'h8130
`define COES_ID_EXT_BIT 29
`define COES_CONS_NODE_LSB 16
`define COES_CONS_TIME_W 16
`define COES_IDENT_CNT 8'h04
`define COES_SUB_CNT_ONE 8'h01
`define COES_MOD_MAX 4'hE
`define COES_ERRB_RST 8'h00
`define COES_ERRB_PREOP 8'h00
`define COES_ERRB_KEEP 8'h01
`define COES_ERRB_STOP 8'h02
`define COES_MS_NS 1000000
`define COES_CLK_NS 10
`define COES_CLK_PER_MS (`COES_MS_NS / `COES_CLK_NS)
`endif

// ---- hw/coes_pkg.sv ----
// Purpose: shared types of the communication supervision block
// Assumes: nothing beyond the constants header
// Notes: state codes follow declaration order, counting from zero
package coes_pkg;
	// network management states seen and requested by the block
	typedef enum logic [1:0] {
		COES_NMT_INIT,
		COES_NMT_STOPPED,
		COES_NMT_PREOP,
		COES_NMT_OPER
	} coes_nmt_t;
endpackage

// ---- hw/coes_supervisor.sv ----
// Purpose: heartbeat, life guarding, emergency id, identity, module list
// Assumes: dictionary requests come from the protocol engine on core_clk
// Notes: node id straps arrive from pins and are synchronised
`timescale 1ns/10ps
`include "coes_defs.svh"
module coes_supervisor #(
	parameter int CLK_PER_MS = `COES_CLK_PER_MS,
	parameter logic [31:0] VENDOR_CODE = 32'h0000_0001, // arbitrary
	parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002, // arbitrary
	parameter logic [7:0] REV_MAJOR = 8'h01,
	parameter logic [7:0] REV_MINOR = 8'h00,
	parameter logic [7:0] REV_PATCH = 8'h00,
	parameter logic [31:0] SERIAL_NUM = 32'h0000_0000 // arbitrary
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic [6:0] node_id_in,
	input wire logic od_rd_in,
	input wire logic od_wr_in,
	input wire logic [15:0] od_index_in,
	input wire logic [7:0] od_sub_in,
	input wire logic [31:0] od_wdata_in,
	output logic od_ack_out,
	output logic od_err_out,
	output logic [31:0] od_rdata_out,
	input wire logic hb_rx_in,
	input wire logic [7:0] hb_rx_node_in,
	input wire logic guard_rx_in,
	input wire logic bus_off_in,
	input wire logic sync_to_in,
	input wire logic pdo_evt_to_in,
	input wire coes_pkg::coes_nmt_t nmt_state_in,
	input wire logic mod_wr_in,
	input wire logic [3:0] mod_wr_pos_in,
	input wire logic [15:0] mod_wr_code_in,
	input wire logic [3:0] mod_count_in,
	output logic hb_tx_out,
	output logic emcy_tx_out,
	output logic [10:0] emcy_cob_out,
	output logic [15:0] emcy_code_out,
	output logic fallback_out,
	output logic nmt_req_out,
	output coes_pkg::coes_nmt_t nmt_req_state_out
);
	// elaboration check: the time base needs two clocks per ms at least
	if (CLK_PER_MS < 2) begin : g_bad_rate
		$error("CLK_PER_MS must be at least 2");
	end

	// millisecond counter expiry shared by the three timers
	function automatic logic ms_due(input logic tick,
		input logic [23:0] cnt, input logic [23:0] lim);
		ms_due = tick && (cnt + 24'h000001 >= lim);
	endfunction

	// node id strap synchroniser, first stage read only by second
	logic [6:0] node_s1_q;
	logic [6:0] node_s2_q;
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			node_s1_q <= 7'h00;
			node_s2_q <= 7'h00;
		end else begin
			node_s1_q <= node_id_in;
			node_s2_q <= node_s1_q;
		end
	end

	// configuration registers
	logic [10:0] emcy_id_q; // written identifier
	logic emcy_set_q; // software has written the identifier
	logic [7:0] cons_node_q; // monitored producer
	logic [15:0] cons_time_q; // consumer timeout in ms
	logic [15:0] prod_time_q; // producer period in ms
	logic [15:0] guard_time_q; // guard time in ms
	logic [7:0] life_fac_q; // lifetime factor
	logic [7:0] errb_q; // error behaviour selection
	logic [15:0] mod_code_q [14]; // attached module product codes

	// default identifier follows the strap until software writes one
	wire [10:0] emcy_eff = emcy_set_q ? emcy_id_q :
		(`COES_EMCY_BASE + {4'h0, node_s2_q});

	// request decode
	wire is_emcy = od_index_in == `COES_IDX_EMCY;
	wire is_cons = od_index_in == `COES_IDX_CONS;
	wire is_prod = od_index_in == `COES_IDX_PROD;
	wire is_ident = od_index_in == `COES_IDX_IDENT;
	wire is_mods = od_index_in == `COES_IDX_MODS;
	wire is_errb = od_index_in == `COES_IDX_ERRB;
	wire is_guard = od_index_in == `COES_IDX_GUARD;
	wire is_life = od_index_in == `COES_IDX_LIFE;
	wire sub0 = od_sub_in == 8'h00;
	wire sub1 = od_sub_in == 8'h01;
	wire mod_sub_ok = (od_sub_in >= 8'h01) && (od_sub_in <= 8'h0E);
	wire [3:0] mod_pos = od_sub_in[3:0] - 4'h1;

	// write checks; reserved bits of the emergency, consumer and behaviour words and extended ids are refused
	wire emcy_ok = od_wdata_in[31:11] == 21'h000000;
	wire cons_ok = od_wdata_in[31:24] == 8'h00;
	// the whole word counts, so upper garbage cannot hide a reserved code
	wire errb_ok = (od_wdata_in[31:8] == 24'h000000) &&
		(od_wdata_in[7:0] <= `COES_ERRB_STOP);
	wire wr_emcy = od_wr_in && is_emcy && sub0 && emcy_ok;
	wire wr_cons = od_wr_in && is_cons && sub1 && cons_ok;
	wire wr_prod = od_wr_in && is_prod && sub0;
	wire wr_guard = od_wr_in && is_guard && sub0;
	wire wr_life = od_wr_in && is_life && sub0;
	wire wr_errb = od_wr_in && is_errb && sub1 && errb_ok;
	wire wr_good = wr_emcy | wr_cons | wr_prod | wr_guard | wr_life |
		wr_errb;

	// read multiplexer; valid is low for unknown entries
	logic [31:0] rd_val;
	logic rd_valid;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_valid = 1'b1;
		if (is_emcy && sub0)
			rd_val = {21'h000000, emcy_eff};
		else if (is_cons && sub0)
			rd_val = {24'h000000, `COES_SUB_CNT_ONE};
		else if (is_cons && sub1)
			rd_val = {8'h00, cons_node_q, cons_time_q};
		else if (is_prod && sub0)
			rd_val = {16'h0000, prod_time_q};
		else if (is_guard && sub0)
			rd_val = {16'h0000, guard_time_q};
		else if (is_life && sub0)
			rd_val = {24'h000000, life_fac_q};
		else if (is_ident && sub0)
			rd_val = {24'h000000, `COES_IDENT_CNT};
		else if (is_ident && od_sub_in == 8'h01)
			rd_val = VENDOR_CODE;
		else if (is_ident && od_sub_in == 8'h02)
			rd_val = PRODUCT_CODE;
		else if (is_ident && od_sub_in == 8'h03)
			rd_val = {8'h00, REV_MAJOR, REV_MINOR, REV_PATCH};
		else if (is_ident && od_sub_in == 8'h04)
			rd_val = SERIAL_NUM;
		else if (is_mods && sub0) begin
			// an empty bus still reports the maximum count
			if (mod_count_in == 4'h0)
				rd_val = {28'h0000000, `COES_MOD_MAX};
			else
				rd_val = {28'h0000000, mod_count_in};
		end else if (is_mods && mod_sub_ok) begin
			// entries past the attached count read zero
			if (mod_pos < mod_count_in)
				rd_val = {16'h0000, mod_code_q[mod_pos]};
			else
				rd_val = 32'h0000_0000;
		end else if (is_errb && sub0)
			rd_val = {24'h000000, `COES_SUB_CNT_ONE};
		else if (is_errb && sub1)
			rd_val = {24'h000000, errb_q};
		else
			rd_valid = 1'b0;
	end

	// answer one cycle after the request
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			od_ack_out <= 1'b0;
			od_err_out <= 1'b0;
			od_rdata_out <= 32'h0000_0000;
		end else begin
			od_ack_out <= od_rd_in | od_wr_in;
			// a write wins if both strobes are raised together
			od_err_out <= od_wr_in ? !wr_good : (od_rd_in && !rd_valid);
			if (od_rd_in && !od_wr_in)
				od_rdata_out <= rd_val;
		end
	end

	// configuration register updates
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			emcy_id_q <= 11'h000;
			emcy_set_q <= 1'b0;
			cons_node_q <= 8'h00;
			cons_time_q <= 16'h0000;
			prod_time_q <= 16'h0000;
			guard_time_q <= 16'h0000;
			life_fac_q <= 8'h00;
			errb_q <= `COES_ERRB_RST;
		end else begin
			if (wr_emcy) begin
				emcy_id_q <= od_wdata_in[10:0];
				emcy_set_q <= 1'b1;
			end
			if (wr_cons) begin
				cons_node_q <= od_wdata_in[23:16];
				cons_time_q <= od_wdata_in[15:0];
			end
			if (wr_prod)
				prod_time_q <= od_wdata_in[15:0];
			if (wr_guard)
				guard_time_q <= od_wdata_in[15:0];
			if (wr_life)
				life_fac_q <= od_wdata_in[7:0];
			if (wr_errb)
				errb_q <= od_wdata_in[7:0];
		end
	end

	// module product codes, loaded by the expansion bus scan
	always_ff @(posedge core_clk_in) begin
		if (mod_wr_in && mod_wr_pos_in < `COES_MOD_MAX)
			mod_code_q[mod_wr_pos_in] <= mod_wr_code_in;
	end

	// free-running millisecond time base
	logic [31:0] pre_q;
	wire ms_tick = pre_q == 32'(CLK_PER_MS - 1);
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			pre_q <= 32'h0000_0000;
		else
			pre_q <= ms_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
	end

	// heartbeat producer; period change restarts the count
	logic [15:0] prod_ms_q;
	wire prod_on = prod_time_q != 16'h0000;
	wire prod_due = prod_on &&
		ms_due(ms_tick, {8'h00, prod_ms_q}, {8'h00, prod_time_q});
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prod_ms_q <= 16'h0000;
			hb_tx_out <= 1'b0;
		end else begin
			hb_tx_out <= prod_due;
			if (wr_prod || !prod_on || prod_due)
				prod_ms_q <= 16'h0000;
			else if (ms_tick)
				prod_ms_q <= prod_ms_q + 16'h0001;
		end
	end

	// heartbeat consumer; armed by a heartbeat, or by a write while the timeout is already nonzero
	logic [15:0] cons_ms_q;
	logic cons_arm_q; // timer running
	wire cons_on = cons_time_q != 16'h0000;
	wire hb_seen = hb_rx_in && hb_rx_node_in == cons_node_q;
	wire cons_to = cons_on && cons_arm_q && !hb_seen &&
		ms_due(ms_tick, {8'h00, cons_ms_q}, {8'h00, cons_time_q});
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cons_ms_q <= 16'h0000;
			cons_arm_q <= 1'b0;
		end else begin
			if (hb_seen || wr_cons || !cons_on) begin
				cons_ms_q <= 16'h0000;
				cons_arm_q <= cons_on;
			end else if (cons_to) begin
				// disarm so a lost producer is reported once
				cons_arm_q <= 1'b0;
			end else if (ms_tick && cons_arm_q)
				cons_ms_q <= cons_ms_q + 16'h0001;
		end
	end

	// life guarding of the master, armed by the first guard request
	logic [23:0] life_ms_q;
	logic life_arm_q;
	// widen before multiplying; a 16-bit product would wrap large limits
	wire [23:0] life_lim = 24'(guard_time_q) * 24'(life_fac_q);
	wire life_on = life_lim != 24'h000000;
	wire life_to = life_on && life_arm_q && !guard_rx_in &&
		ms_due(ms_tick, life_ms_q, life_lim);
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			life_ms_q <= 24'h000000;
			life_arm_q <= 1'b0;
		end else begin
			if (guard_rx_in || !life_on) begin
				life_ms_q <= 24'h000000;
				life_arm_q <= life_on && guard_rx_in;
			end else if (life_to)
				life_arm_q <= 1'b0;
			else if (ms_tick && life_arm_q)
				life_ms_q <= life_ms_q + 24'h000001;
		end
	end

	// bus-off is a level; only its onset counts as a failure
	logic bus_off_q;
	wire bus_off_rise = bus_off_in && !bus_off_q;
	wire fail = bus_off_rise | cons_to | life_to | sync_to_in |
		pdo_evt_to_in;

	// state change selection on failure
	wire go_preop = errb_q == `COES_ERRB_PREOP &&
		nmt_state_in == coes_pkg::COES_NMT_OPER;
	wire go_stop = errb_q == `COES_ERRB_STOP;

	// emergency, fallback and state requests
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bus_off_q <= 1'b0;
			emcy_tx_out <= 1'b0;
			emcy_cob_out <= 11'h000;
			emcy_code_out <= 16'h0000;
			fallback_out <= 1'b0;
			nmt_req_out <= 1'b0;
			nmt_req_state_out <= coes_pkg::COES_NMT_INIT;
		end else begin
			bus_off_q <= bus_off_in;
			emcy_cob_out <= emcy_eff;
			emcy_tx_out <= cons_to | life_to;
			if (cons_to | life_to)
				emcy_code_out <= `COES_EMCY_HB_CODE;
			// fallback holds until the producer is heard again or the consumer is disabled
			if (cons_to)
				fallback_out <= 1'b1;
			else if (hb_seen || !cons_on)
				fallback_out <= 1'b0;
			nmt_req_out <= fail && (go_preop || go_stop);
			if (fail && go_stop)
				nmt_req_state_out <= coes_pkg::COES_NMT_STOPPED;
			else if (fail && go_preop)
				nmt_req_state_out <= coes_pkg::COES_NMT_PREOP;
		end
	end
endmodule

// ---- testbench/coes_supervisor_monitor.sv ----
// Purpose: port checks on the supervision block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module coes_supervisor_monitor (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic od_rd_in,
	input wire logic od_wr_in,
	input wire logic [15:0] od_index_in,
	input wire logic [31:0] od_wdata_in,
	input wire logic od_ack_out,
	input wire logic od_err_out,
	input wire logic hb_tx_out,
	input wire logic emcy_tx_out,
	input wire logic [15:0] emcy_code_out,
	input wire logic fallback_out,
	input wire logic nmt_req_out,
	input wire coes_pkg::coes_nmt_t nmt_req_state_out,
	input wire coes_pkg::coes_nmt_t nmt_state_in
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// a strobe, then its refusal on the next cycle
	sequence s_req;
		od_rd_in || od_wr_in;
	endsequence
	sequence s_refuse;
		##1 od_ack_out && od_err_out;
	endsequence
	ack_timing_a: assert property (s_req |=> od_ack_out)
		else $error("no answer after a strobe");
	ack_cause_a: assert property (od_ack_out |-> $past(od_rd_in || od_wr_in))
		else $error("answer without a strobe");
	emcy_ext_a: assert property (od_wr_in && od_index_in == 16'h1014 &&
		od_wdata_in[31:11] != 21'h0 |-> s_refuse)
		else $error("wide emergency id accepted");
	ident_ro_a: assert property (od_wr_in && od_index_in == 16'h1018
		|-> s_refuse)
		else $error("identity write accepted");
	errb_rsv_a: assert property (od_wr_in && od_index_in == 16'h1029 &&
		od_wdata_in > 32'h2 |-> s_refuse)
		else $error("reserved behaviour accepted");
	emcy_code_a: assert property (emcy_tx_out |-> emcy_code_out == 16'h8130)
		else $error("wrong emergency code");
	emcy_pulse_a: assert property (emcy_tx_out |=> !emcy_tx_out)
		else $error("emergency held high");
	hb_pulse_a: assert property (hb_tx_out |=> !hb_tx_out [*2])
		else $error("heartbeat held high");
	fb_rise_a: assert property ($rose(fallback_out)
		|-> emcy_tx_out || $past(emcy_tx_out))
		else $error("fallback without emergency");
	nmt_target_a: assert property (nmt_req_out |-> nmt_req_state_out inside
		{coes_pkg::COES_NMT_PREOP, coes_pkg::COES_NMT_STOPPED})
		else $error("bad state request");
	preop_cond_a: assert property (nmt_req_out &&
		nmt_req_state_out == coes_pkg::COES_NMT_PREOP
		|-> $past(nmt_state_in) == coes_pkg::COES_NMT_OPER)
		else $error("preop request outside operational");
endmodule
bind coes_supervisor coes_supervisor_monitor i_coes_supervisor_monitor (
	.core_clk_in, .arst_n_in, .od_rd_in, .od_wr_in, .od_index_in,
	.od_wdata_in, .od_ack_out, .od_err_out, .hb_tx_out, .emcy_tx_out,
	.emcy_code_out, .fallback_out, .nmt_req_out, .nmt_req_state_out,
	.nmt_state_in);

// ---- testbench/coes_master_model.sv ----
// Purpose: network master stand-in sending heartbeat frames
// Assumes: a frame is reduced to a one-cycle receive pulse
// Notes: source node may change in mid-run to model a lost producer
`timescale 1ns/10ps
module coes_master_model (
	input wire logic clk_in,
	input wire logic en_in,
	input wire logic [7:0] node_in,
	output logic hb_rx_out = 1'b0,
	output logic [7:0] hb_node_out = 8'h00
);
	int cnt = 0; // cycles since the last frame
	// one frame every ten cycles; node line scrambled between frames
	always @(negedge clk_in) begin
		cnt = (en_in && cnt < 9) ? cnt + 1 : 0;
		hb_rx_out <= en_in && cnt == 0;
		hb_node_out <= (en_in && cnt == 0) ? node_in : ~node_in;
	end
endmodule

// ---- testbench/coes_supervisor_tb.sv ----
// Purpose: self-checking bench for the supervision block
// Assumes: answers one cycle after a strobe, ms shortened to ten clocks
// Notes: expected values come from the model variables below
`timescale 1ns/10ps
`include "coes_defs.svh"
`define CHK(n, e, a) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		fail_count++; \
		$display("Error %s exp %0h got %0h", n, e, a); \
	end \
end
module coes_supervisor_tb;
	localparam logic [31:0] VEND = 32'h0000_00A5; // arbitrary
	localparam logic [31:0] PROD = 32'h0000_0C3C; // arbitrary
	localparam logic [31:0] SER = 32'h0000_1234; // arbitrary
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, guard = 1'b0;
	logic bus_off = 1'b0, sync_to = 1'b0, pdo_to = 1'b0, mod_wr = 1'b0;
	logic hb_en = 1'b0, ack, err, hb_tx, emcy, fb, nreq, hb_rx, hit;
	logic [6:0] node = 7'h00;
	logic [15:0] idx = 16'h0000, mcode = 16'h0000, ecode;
	logic [7:0] sub = 8'h00, hb_src = 8'h05, hb_node;
	logic [31:0] wd = 32'h0, rdata;
	logic [31:0] ident [5] = '{32'h4, VEND, PROD, 32'h0002_0304, SER};
	logic [3:0] mpos = 4'h0, mcnt = 4'h0;
	logic [10:0] cob;
	coes_pkg::coes_nmt_t st = coes_pkg::COES_NMT_OPER, nst, tgt;
	int fail_count = 0, comparisons = 0, cyc = 0, seed = 32'hc8bc988b;
	int errb_m = 0, n_emcy = 0, n_hb = 0, last_hb = 0, gap = 0;
	int mods_q[$]; // model of the attached module codes
	coes_supervisor #(.CLK_PER_MS(10), .VENDOR_CODE(VEND),
		.PRODUCT_CODE(PROD), .REV_MAJOR(8'h02), .REV_MINOR(8'h03),
		.REV_PATCH(8'h04), .SERIAL_NUM(SER)) i_coes_supervisor (
		.core_clk_in(clk), .arst_n_in(rst_n), .node_id_in(node),
		.od_rd_in(rd), .od_wr_in(wr), .od_index_in(idx), .od_sub_in(sub),
		.od_wdata_in(wd), .od_ack_out(ack), .od_err_out(err),
		.od_rdata_out(rdata), .hb_rx_in(hb_rx), .hb_rx_node_in(hb_node),
		.guard_rx_in(guard), .bus_off_in(bus_off), .sync_to_in(sync_to),
		.pdo_evt_to_in(pdo_to), .nmt_state_in(st), .mod_wr_in(mod_wr),
		.mod_wr_pos_in(mpos), .mod_wr_code_in(mcode), .mod_count_in(mcnt),
		.hb_tx_out(hb_tx), .emcy_tx_out(emcy), .emcy_cob_out(cob),
		.emcy_code_out(ecode), .fallback_out(fb), .nmt_req_out(nreq),
		.nmt_req_state_out(nst));
	coes_master_model i_coes_master_model (.clk_in(clk), .en_in(hb_en),
		.node_in(hb_src), .hb_rx_out(hb_rx), .hb_node_out(hb_node));
	initial begin
		forever #5 clk = ~clk;
	end
	// pulse counters and hang guard, off the sampling edge
	always @(negedge clk) begin
		cyc++;
		if (emcy === 1'b1) n_emcy++;
		if (hb_tx === 1'b1) begin
			gap = cyc - last_hb;
			last_hb = cyc;
			n_hb++;
		end
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one access entered at a falling edge; d is write data or read result
	task automatic od(input logic w, input logic [15:0] i,
		input logic [7:0] s, input logic [31:0] d, input logic e);
		wr = w;
		rd = !w;
		idx = i;
		sub = s;
		wd = d;
		@(negedge clk);
		`CHK("ack", 1'b1, ack)
		`CHK("err", e, err)
		if (!w && !e) `CHK("rdata", d, rdata)
		wr = 1'b0;
		rd = 1'b0;
		@(negedge clk);
	endtask
	// raise one failure kind and watch for the state request
	task automatic fail_chk(input int k);
		hit = 1'b0;
		st = (k == 1) ? coes_pkg::COES_NMT_PREOP : coes_pkg::COES_NMT_OPER;
		@(negedge clk);
		sync_to = (k == 0);
		pdo_to = (k == 1);
		bus_off = (k == 2);
		repeat (4) begin
			@(negedge clk);
			sync_to = 1'b0;
			pdo_to = 1'b0;
			if (nreq === 1'b1) begin
				hit = 1'b1;
				tgt = nst;
			end
		end
		bus_off = 1'b0;
		`CHK("nmt req", errb_m == 2 || (errb_m == 0 && k != 1), hit)
		if (hit) `CHK("nmt tgt", errb_m == 2 ? coes_pkg::COES_NMT_STOPPED :
			coes_pkg::COES_NMT_PREOP, tgt)
	endtask
	initial begin
		node = 7'($random(seed));
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		od(0, `COES_IDX_EMCY, 0, 32'h80 + node, 0);
		`CHK("cob dflt", 11'h080 + 11'(node), cob)
		od(1, `COES_IDX_EMCY, 0, 32'h2000_0181, 1);
		od(0, `COES_IDX_EMCY, 0, 32'h80 + node, 0);
		od(1, `COES_IDX_EMCY, 0, 32'h0000_0123, 0);
		`CHK("cob", 11'h123, cob)
		for (int s = 0; s < 5; s++) od(0, `COES_IDX_IDENT, s, ident[s], 0);
		od(1, `COES_IDX_IDENT, 1, 32'h0, 1);
		od(0, `COES_IDX_MODS, 0, 32'hE, 0);
		od(0, `COES_IDX_MODS, 1, 32'h0, 0);
		for (int p = 0; p < 3; p++) begin
			mods_q.push_back($random(seed) & 32'hFFFF);
			mod_wr = 1'b1;
			mpos = 4'(p);
			mcode = 16'(mods_q[p]);
			@(negedge clk);
		end
		mod_wr = 1'b0;
		mcnt = 4'h3;
		for (int s = 0; s < 5; s++) od(0, `COES_IDX_MODS, s, s == 0 ? 3 :
			(s < 4 ? mods_q[s - 1] : 0), 0);
		for (int v = 0; v < 4; v++) begin
			od(1, `COES_IDX_ERRB, 1, v, v > 2);
			if (v < 3) errb_m = v;
			od(0, `COES_IDX_ERRB, 1, errb_m, 0);
			for (int k = 0; k < 3; k++) fail_chk(k);
		end
		`CHK("hb idle", 0, n_hb)
		od(1, `COES_IDX_PROD, 0, 32'h3, 0);
		od(0, `COES_IDX_PROD, 0, 32'h3, 0);
		repeat (100) @(negedge clk);
		`CHK("hb gap", 30, gap)
		od(1, `COES_IDX_PROD, 0, 32'h0, 0);
		@(posedge clk) n_hb = 0;
		repeat (100) @(negedge clk);
		`CHK("hb off", 0, n_hb)
		// producer already beating when monitoring is armed
		hb_en = 1'b1;
		od(1, `COES_IDX_CONS, 1, 32'h0105_0002, 1);
		od(1, `COES_IDX_CONS, 1, 32'h0005_0002, 0);
		od(0, `COES_IDX_CONS, 1, 32'h0005_0002, 0);
		@(posedge clk) n_emcy = 0;
		repeat (100) @(negedge clk);
		`CHK("emcy alive", 0, n_emcy)
		hb_src = 8'h06;
		repeat (60) @(negedge clk);
		`CHK("emcy lost", 1, n_emcy)
		`CHK("fallback", 1'b1, fb)
		`CHK("emcy code", `COES_EMCY_HB_CODE, ecode)
		hb_src = 8'h05;
		repeat (30) @(negedge clk);
		`CHK("fb clear", 1'b0, fb)
		od(1, `COES_IDX_CONS, 1, 32'h0005_0000, 0);
		hb_en = 1'b0;
		@(posedge clk) n_emcy = 0;
		repeat (60) @(negedge clk);
		`CHK("emcy off", 0, n_emcy)
		od(1, `COES_IDX_GUARD, 0, 32'h2, 0);
		od(1, `COES_IDX_LIFE, 0, 32'h2, 0);
		guard = 1'b1;
		@(negedge clk) guard = 1'b0;
		@(posedge clk) n_emcy = 0;
		repeat (25) @(negedge clk);
		`CHK("life early", 0, n_emcy)
		repeat (35) @(negedge clk);
		`CHK("life lost", 1, n_emcy)
		end_sim();
	end
endmodule
